// ===== hdl/pmx_pkg.sv
// Constants for the port pin multiplexer: port table, register codes,
// reset values and strap timing.
// Assumes one system clock of 50 MHz; used by pmx_port_mux and pmx_port_cell.
package pmx_pkg;

   localparam int NPORT = 5;
   localparam int PW = 8;

   // Port slots in the flattened pin vectors
   localparam logic [2:0] PORT_TIMER = 3'h0;
   localparam logic [2:0] PORT_SERIAL = 3'h1;
   localparam logic [2:0] PORT_DATA_HI = 3'h2;
   localparam logic [2:0] PORT_ANALOG = 3'h3;
   localparam logic [2:0] PORT_MISC = 3'h4;

   // Register select codes on the access strobes
   localparam logic [2:0] REG_LATCH = 3'h0;
   localparam logic [2:0] REG_DIR = 3'h1;
   localparam logic [2:0] REG_MODE = 3'h2;
   localparam logic [2:0] REG_ALT = 3'h3;
   localparam logic [2:0] REG_MEM_MODE = 3'h4;

   // Bits that exist on each port
   localparam logic [7:0] PRESENT_MASK [NPORT] =
      '{8'hF5, 8'hFD, 8'hFF, 8'h0F, 8'hC0};
   // Bits with a working output buffer
   localparam logic [7:0] IO_MASK [NPORT] =
      '{8'hF5, 8'hFC, 8'hFF, 8'h00, 8'hC0};
   // Bits whose mode bit software may change
   localparam logic [7:0] CTL_MASK [NPORT] =
      '{8'hF5, 8'hFC, 8'h00, 8'h00, 8'hC0};
   // Mode bits stuck at one by hardware
   localparam logic [7:0] MODE_FIX1 [NPORT] =
      '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] MODE_RST [NPORT] =
      '{8'h00, 8'h01, 8'h00, 8'h00, 8'hC0};
   // Bits with two control functions
   localparam logic [7:0] ALT_MASK [NPORT] =
      '{8'hF0, 8'h00, 8'h00, 8'h00, 8'h00};
   // Timer and interrupt-type inputs with noise filter
   localparam logic [7:0] FILT_MASK [NPORT] =
      '{8'h04, 8'h01, 8'h00, 8'h00, 8'h00};

   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'hFF;
   localparam logic [7:0] ALT_RST = 8'h00;

   localparam logic [7:0] MEM_MODE_RST = 8'h00;
   localparam int MM_DATA_HI_BIT = 0;
   localparam logic [7:0] MISC_SYSTEM_CLOCK_OUT_PIN_MASK = 8'h80;

   // Samples that must agree before a filtered level moves
   localparam int FILT_LEN = 3;

   // Strap is read once the pin synchroniser has settled
   localparam int CLK_PERIOD_NS = 20;
   localparam int STRAP_SETTLE_NS = 40;
   localparam logic [1:0] STRAP_CYCLES =
      2'((STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// ===== hdl/pmx_port_cell.sv
// One 8-bit port: latch, direction, mode and select bits, pin synchroniser,
// noise filter and the output selector.
// Assumes write strobes come already expanded to a bit mask.
`timescale 1ns/1ns
module pmx_port_cell #(
   parameter logic [7:0] PRESENT = 8'hFF,
   parameter logic [7:0] IO = 8'hFF,
   parameter logic [7:0] CTL = 8'h00,
   parameter logic [7:0] FIX1 = 8'h00,
   parameter logic [7:0] MRST = 8'h00,
   parameter logic [7:0] ALT = 8'h00,
   parameter logic [7:0] FILT = 8'h00
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_stb_i,
   input wire logic [2:0] wr_reg_i,
   input wire logic [7:0] wr_mask_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [7:0] force_ctl_i,
   input wire logic [7:0] pin_i,
   input wire logic [7:0] ctl_out_i,
   input wire logic [7:0] ctl_oe_i,
   output logic [7:0] pin_o,
   output logic [7:0] pin_oe_o,
   output logic [7:0] ctl_in0_o,
   output logic [7:0] ctl_in1_o,
   output logic [7:0] ctl_edge_o,
   output logic [7:0] latch_o,
   output logic [7:0] dir_o,
   output logic [7:0] mode_o,
   output logic [7:0] alt_o,
   output logic [7:0] pin_read_select_o
);
   logic [7:0] sync1;
   logic [7:0] sync2;
   logic [7:0] filt;
   logic [7:0] filt_q;
   logic [7:0] sel_q;
   logic [7:0] eff_mode;
   logic [7:0] next_val [4];

   assign eff_mode = mode_o | force_ctl_i;

   always_comb begin
      next_val[0] = (latch_o & ~wr_mask_i) | (wr_data_i & wr_mask_i);
      next_val[1] = (dir_o & ~wr_mask_i) | (wr_data_i & wr_mask_i);
      next_val[2] = (mode_o & ~wr_mask_i) | (wr_data_i & wr_mask_i);
      next_val[3] = (alt_o & ~wr_mask_i) | (wr_data_i & wr_mask_i);
   end

   // Latch takes writes whatever the direction or mode
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         latch_o <= pmx_pkg::LATCH_RST;
      end else if (wr_stb_i && wr_reg_i == pmx_pkg::REG_LATCH) begin
         latch_o <= next_val[0] & IO;
      end
   end

   // Bits without an output buffer stay inputs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dir_o <= pmx_pkg::DIR_RST;
      end else if (wr_stb_i && wr_reg_i == pmx_pkg::REG_DIR) begin
         dir_o <= next_val[1] | ~IO;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_o <= MRST;
      end else if (wr_stb_i && wr_reg_i == pmx_pkg::REG_MODE) begin
         mode_o <= (next_val[2] & CTL) | FIX1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         alt_o <= pmx_pkg::ALT_RST;
      end else if (wr_stb_i && wr_reg_i == pmx_pkg::REG_ALT) begin
         alt_o <= next_val[3] & ALT;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1 <= 8'h00;
         sync2 <= 8'h00;
      end else begin
         sync1 <= pin_i;
         sync2 <= sync1;
      end
   end

   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_bit
         logic [pmx_pkg::FILT_LEN-1:0] hist;
         logic level;
         // One process per bit owns its own level; the vector is gathered
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               hist <= '0;
               level <= 1'b0;
            end else begin
               hist <= {hist[pmx_pkg::FILT_LEN-2:0], sync2[b]};
               // Short glitches on filtered bits never reach the peripheral; unfiltered bits follow sync2 directly
               if (!FILT[b]) begin
                  level <= sync2[b];
               end else if (&hist) begin
                  level <= 1'b1;
               end else if (~|hist) begin
                  level <= 1'b0;
               end
            end
         end
         assign filt[b] = level;
      end
   endgenerate

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         filt_q <= 8'h00;
         ctl_in0_o <= 8'h00;
         ctl_in1_o <= 8'h00;
         ctl_edge_o <= 8'h00;
      end else begin
         filt_q <= filt;
         // Select bit acts only while in control mode
         ctl_in0_o <= filt & eff_mode & ~alt_o & PRESENT;
         ctl_in1_o <= filt & eff_mode & alt_o & PRESENT;
         ctl_edge_o <= filt & ~filt_q & eff_mode & FILT;
      end
   end

   // Selector lags the mode bit one cycle, so the latch shows briefly
   // on entry to control mode; software hides it with an idle latch.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_q <= 8'h00;
         pin_o <= 8'h00;
         pin_oe_o <= 8'h00;
      end else begin
         sel_q <= eff_mode;
         pin_o <= ((sel_q & ctl_out_i) | (~sel_q & latch_o)) & IO;
         // Direction 0 drives, 1 floats; mode 1 hands over
         pin_oe_o <= ((eff_mode & ctl_oe_i) | (~eff_mode & ~dir_o)) & IO;
      end
   end

   // Per-bit read path: pin for inputs, latch for outputs
   assign pin_read_select_o = ((dir_o & sync2) | (~dir_o & latch_o)) & PRESENT;

endmodule

// ===== hdl/pmx_port_mux.sv
// Top of the port pin multiplexer: five ports with register strobes,
// memory-mode assignment of the upper data bus, clock and wait pins.
// Assumes pins and the strap arrive asynchronously; peripheral signals
// and strobes come from logic on CLK_SYS_I.
`timescale 1ns/1ns
module pmx_port_mux (
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire logic ROMLESS_MODE1_I,
   input wire logic WR_STB_I,
   input wire logic [2:0] WR_PORT_I,
   input wire logic [2:0] WR_REG_I,
   input wire logic WR_BIT_I,
   input wire logic [2:0] WR_BITNUM_I,
   input wire logic [7:0] WR_DATA_I,
   input wire logic RD_STB_I,
   input wire logic [2:0] RD_PORT_I,
   input wire logic [2:0] RD_REG_I,
   input wire logic RD_BIT_I,
   input wire logic [2:0] RD_BITNUM_I,
   output logic [7:0] RD_DATA_O,
   output logic RD_VALID_O,
   input wire logic [39:0] PIN_I,
   output logic [39:0] PIN_O,
   output logic [39:0] PIN_OE_O,
   input wire logic [39:0] CTL_OUT_I,
   input wire logic [39:0] CTL_OE_I,
   output logic [39:0] CTL_IN0_O,
   output logic [39:0] CTL_IN1_O,
   output logic [39:0] CTL_EDGE_O,
   output logic [7:0] MEM_MODE_O
);
   logic [7:0] wr_mask;
   logic [7:0] wr_data;
   logic strap_s1;
   logic strap_s2;
   logic [1:0] strap_cnt;
   logic strap_done;
   logic clk_div;
   logic [39:0] ctl_out;
   logic [39:0] ctl_oe;
   logic [39:0] force_ctl;
   logic [7:0] reg_latch [pmx_pkg::NPORT];
   logic [7:0] reg_dir [pmx_pkg::NPORT];
   logic [7:0] reg_mode [pmx_pkg::NPORT];
   logic [7:0] reg_alt [pmx_pkg::NPORT];
   logic [7:0] pin_read_select [pmx_pkg::NPORT];
   logic [7:0] rd_word;

   // Single-bit writes become a one-hot mask with data replicated
   always_comb begin
      if (WR_BIT_I) begin
         wr_mask = 8'h01 << WR_BITNUM_I;
         wr_data = {8{WR_DATA_I[0]}};
      end else begin
         wr_mask = 8'hFF;
         wr_data = WR_DATA_I;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         strap_s1 <= 1'b0;
         strap_s2 <= 1'b0;
      end else begin
         strap_s1 <= ROMLESS_MODE1_I;
         strap_s2 <= strap_s1;
      end
   end

   // Strap is taken a few cycles after release, never inside reset
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         strap_cnt <= 2'h0;
         strap_done <= 1'b0;
      end else if (!strap_done) begin
         strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == pmx_pkg::STRAP_CYCLES) begin
            strap_done <= 1'b1;
         end
      end
   end

   // Memory-mode setting owns the upper data bus pins
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         MEM_MODE_O <= pmx_pkg::MEM_MODE_RST;
      end else if (WR_STB_I && WR_REG_I == pmx_pkg::REG_MEM_MODE) begin
         MEM_MODE_O <= (MEM_MODE_O & ~wr_mask) | (wr_data & wr_mask);
      end else if (!strap_done && strap_cnt == pmx_pkg::STRAP_CYCLES) begin
         // Mode 0 gives bus lines, mode 1 plain inputs
         MEM_MODE_O[pmx_pkg::MM_DATA_HI_BIT] <= ~strap_s2;
      end
   end

   // Clock output runs at half the system clock rate
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         clk_div <= 1'b0;
      end else begin
         clk_div <= ~clk_div;
      end
   end

   always_comb begin
      ctl_out = CTL_OUT_I;
      ctl_oe = CTL_OE_I;
      force_ctl = 40'h00_0000_0000;
      // Clock output pin is driven by the divider, not a peripheral
      ctl_out[8*pmx_pkg::PORT_MISC+7] = clk_div;
      ctl_oe[8*pmx_pkg::PORT_MISC+7] = 1'b1;
      // Wait pin is only an input in control mode
      ctl_oe[8*pmx_pkg::PORT_MISC+6] = 1'b0;
      // Interrupt bit never drives its pin
      ctl_oe[8*pmx_pkg::PORT_SERIAL] = 1'b0;
      // Analog pins carry no output at all
      ctl_oe[8*pmx_pkg::PORT_ANALOG +: 8] = 8'h00;
      force_ctl[8*pmx_pkg::PORT_DATA_HI +: 8] =
         {8{MEM_MODE_O[pmx_pkg::MM_DATA_HI_BIT]}};
   end

   genvar p;
   generate
      for (p = 0; p < pmx_pkg::NPORT; p++) begin : g_port
         logic hit;
         assign hit = WR_STB_I && (WR_PORT_I == 3'(p))
                      && (WR_REG_I != pmx_pkg::REG_MEM_MODE);
         pmx_port_cell #(
            .PRESENT(pmx_pkg::PRESENT_MASK[p]),
            .IO(pmx_pkg::IO_MASK[p]),
            .CTL(pmx_pkg::CTL_MASK[p]),
            .FIX1(pmx_pkg::MODE_FIX1[p]),
            .MRST(pmx_pkg::MODE_RST[p]),
            .ALT(pmx_pkg::ALT_MASK[p]),
            .FILT(pmx_pkg::FILT_MASK[p])
         ) u_cell (
            .clk_i(CLK_SYS_I),
            .rst_i(RST_I),
            .wr_stb_i(hit),
            .wr_reg_i(WR_REG_I),
            .wr_mask_i(wr_mask),
            .wr_data_i(wr_data),
            .force_ctl_i(force_ctl[8*p +: 8]),
            .pin_i(PIN_I[8*p +: 8]),
            .ctl_out_i(ctl_out[8*p +: 8]),
            .ctl_oe_i(ctl_oe[8*p +: 8]),
            .pin_o(PIN_O[8*p +: 8]),
            .pin_oe_o(PIN_OE_O[8*p +: 8]),
            .ctl_in0_o(CTL_IN0_O[8*p +: 8]),
            .ctl_in1_o(CTL_IN1_O[8*p +: 8]),
            .ctl_edge_o(CTL_EDGE_O[8*p +: 8]),
            .latch_o(reg_latch[p]),
            .dir_o(reg_dir[p]),
            .mode_o(reg_mode[p]),
            .alt_o(reg_alt[p]),
            .pin_read_select_o(pin_read_select[p])
         );
      end
   endgenerate

   // Missing bits read as zero; unmapped port numbers read as zero for every register code but the memory-mode code
   always_comb begin
      rd_word = 8'h00;
      if (RD_REG_I == pmx_pkg::REG_MEM_MODE) begin
         rd_word = MEM_MODE_O;
      end else if (RD_PORT_I < 3'(pmx_pkg::NPORT)) begin
         unique case (RD_REG_I)
            pmx_pkg::REG_LATCH: rd_word = pin_read_select[RD_PORT_I];
            pmx_pkg::REG_DIR: rd_word = reg_dir[RD_PORT_I]
                                 & pmx_pkg::PRESENT_MASK[RD_PORT_I];
            pmx_pkg::REG_MODE: rd_word = reg_mode[RD_PORT_I];
            pmx_pkg::REG_ALT: rd_word = reg_alt[RD_PORT_I];
            default: rd_word = 8'h00;
         endcase
      end
   end

   // Read answer one cycle after the strobe; bit reads land in bit 0
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         RD_DATA_O <= 8'h00;
         RD_VALID_O <= 1'b0;
      end else begin
         RD_VALID_O <= RD_STB_I;
         if (RD_STB_I) begin
            if (RD_BIT_I) begin
               RD_DATA_O <= {7'h00, rd_word[RD_BITNUM_I]};
            end else begin
               RD_DATA_O <= rd_word;
            end
         end
      end
   end

endmodule

// ===== tb/pmx_far_model.sv
// Far side of the port mux: board pins and on-chip peripherals.
// Assumes the bench sets board levels and peripheral drive.
`timescale 1ns/1ns
module pmx_far_model (
   input wire logic clk_i,
   input wire logic [39:0] pin_o_i,
   input wire logic [39:0] pin_oe_i,
   input wire logic [39:0] board_lvl_i,
   input wire logic [39:0] per_out_i,
   input wire logic [39:0] per_oe_i,
   output logic [39:0] pin_lvl_o,
   output logic [39:0] ctl_out_o,
   output logic [39:0] ctl_oe_o
);
   // A driven pin shows the mux value, else the board level
   assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & board_lvl_i);
   // Peripherals launch from the system clock like real on-chip logic
   always_ff @(posedge clk_i) begin
      ctl_out_o <= per_out_i;
      ctl_oe_o <= per_oe_i;
   end
endmodule

// ===== tb/pmx_port_mux_bench.sv
// Self-checking bench for pmx_port_mux with the far-side model.
// Assumes the design, package and model files are compiled first.
`timescale 1ns/1ns
module pmx_port_mux_bench;
   logic CLK_SYS_I = 1'b0;
   logic RST_I = 1'b1;
   logic strap = 1'b0;
   logic wstb = 1'b0, wbit = 1'b0, rstb = 1'b0, rbit = 1'b0;
   logic [2:0] wport = 3'h0, wreg = 3'h0, wnum = 3'h0;
   logic [2:0] rport = 3'h0, rreg = 3'h0, rnum = 3'h0;
   logic [7:0] wdata = 8'h00, rdata, mm, d;
   logic rvalid;
   logic [39:0] pin_in, pin_out, pin_oe, ctl_out, ctl_oe, in0, in1, edg;
   logic [39:0] board = 40'h0, per_out = 40'h0, per_oe = 40'h0;
   logic [7:0] expq [$];
   int n_fail = 0, num_checks = 0, cyc = 0, hits, nmi_hits;
   pmx_port_mux dut (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
      .ROMLESS_MODE1_I(strap), .WR_STB_I(wstb), .WR_PORT_I(wport),
      .WR_REG_I(wreg), .WR_BIT_I(wbit), .WR_BITNUM_I(wnum),
      .WR_DATA_I(wdata), .RD_STB_I(rstb), .RD_PORT_I(rport),
      .RD_REG_I(rreg), .RD_BIT_I(rbit), .RD_BITNUM_I(rnum),
      .RD_DATA_O(rdata), .RD_VALID_O(rvalid), .PIN_I(pin_in),
      .PIN_O(pin_out), .PIN_OE_O(pin_oe), .CTL_OUT_I(ctl_out),
      .CTL_OE_I(ctl_oe), .CTL_IN0_O(in0), .CTL_IN1_O(in1),
      .CTL_EDGE_O(edg), .MEM_MODE_O(mm));
   pmx_far_model u_far (.clk_i(CLK_SYS_I), .pin_o_i(pin_out),
      .pin_oe_i(pin_oe), .board_lvl_i(board), .per_out_i(per_out),
      .per_oe_i(per_oe), .pin_lvl_o(pin_in), .ctl_out_o(ctl_out),
      .ctl_oe_o(ctl_oe));
   always #10 CLK_SYS_I = ~CLK_SYS_I;
   task automatic chk(input logic [39:0] seen, input logic [39:0] want);
      num_checks++;
      if (seen !== want) begin
         n_fail++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic cy(input int k);
      repeat (k) @(negedge CLK_SYS_I);
   endtask
   task automatic wr(input logic [2:0] p, input logic [2:0] r,
         input logic b, input logic [2:0] n, input logic [7:0] v);
      @(negedge CLK_SYS_I);
      {wstb, wport, wreg, wbit, wnum, wdata} = {1'b1, p, r, b, n, v};
      @(negedge CLK_SYS_I);
      wstb = 1'b0;
   endtask
   task automatic rd(input logic [2:0] p, input logic [2:0] r,
         input logic b, input logic [2:0] n, input logic [7:0] want);
      @(negedge CLK_SYS_I);
      {rstb, rport, rreg, rbit, rnum} = {1'b1, p, r, b, n};
      expq.push_back(want);
      @(negedge CLK_SYS_I);
      rstb = 1'b0;
   endtask
   task automatic test_done;
      // Every noted read must have been answered
      chk(40'(expq.size()), 40'h0);
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Read answers are matched in order against the driver's notes
   always @(negedge CLK_SYS_I) begin
      if (rvalid === 1'b1) begin
         if (expq.size() == 0) begin
            chk(1'b1, 1'b0);
         end else begin
            chk(rdata, expq.pop_front());
         end
      end
   end
   always @(posedge CLK_SYS_I) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      void'($urandom(50424));
      per_oe[23:16] = 8'($urandom);
      cy(10);
      RST_I = 1'b0;
      cy(6);
      chk(pin_oe[7:0], 40'h0);
      chk(pin_oe[23:16], per_oe[23:16]);
      d[0] = pin_out[39];
      cy(1);
      chk({pin_oe[39], pin_out[39]}, {1'b1, ~d[0]});
      rd(0, pmx_pkg::REG_DIR, 0, 0, 8'hF5);
      rd(1, pmx_pkg::REG_MODE, 0, 0, 8'h01);
      rd(4, pmx_pkg::REG_MODE, 0, 0, 8'hC0);
      $display("done: reset state");
      d = 8'($urandom);
      board[7:0] = 8'($urandom);
      wr(0, pmx_pkg::REG_LATCH, 0, 0, d);
      wr(0, pmx_pkg::REG_DIR, 1, 0, 8'h00);
      wr(0, pmx_pkg::REG_DIR, 1, 5, 8'h00);
      cy(3);
      chk(pin_oe[7:0], 40'h21);
      chk({pin_out[5], pin_out[0]}, {d[5], d[0]});
      rd(0, pmx_pkg::REG_DIR, 0, 0, 8'hD4);
      rd(0, pmx_pkg::REG_LATCH, 1, 0, {7'h0, d[0]});
      rd(0, pmx_pkg::REG_LATCH, 1, 2, {7'h0, board[2]});
      $display("done: byte and bit access");
      per_out[0] = 1'b1;
      per_oe[0] = 1'b1;
      wr(0, pmx_pkg::REG_LATCH, 1, 0, 8'h00);
      wr(0, pmx_pkg::REG_MODE, 1, 0, 8'h01);
      cy(1);
      chk({pin_oe[0], pin_out[0]}, 2'h2);
      cy(1);
      chk({pin_oe[0], pin_out[0]}, 2'h3);
      per_out[0] = 1'b0;
      cy(2);
      chk(pin_out[0], 1'b0);
      per_out[0] = 1'b1;
      wr(0, pmx_pkg::REG_MODE, 1, 0, 8'h00);
      cy(3);
      chk(pin_out[0], 1'b0);
      $display("done: control mode");
      board[4] = 1'b1;
      board[2] = 1'b0;
      wr(0, pmx_pkg::REG_ALT, 1, 4, 8'h01);
      cy(5);
      chk(in1[4], 1'b0);
      wr(0, pmx_pkg::REG_MODE, 1, 4, 8'h01);
      cy(5);
      chk({in1[4], in0[4]}, 2'h2);
      wr(0, pmx_pkg::REG_ALT, 1, 4, 8'h00);
      cy(5);
      chk({in1[4], in0[4]}, 2'h1);
      $display("done: function select");
      wr(0, pmx_pkg::REG_MODE, 1, 2, 8'h01);
      cy(4);
      board[2] = 1'b1;
      hits = 0;
      repeat (12) begin
         @(negedge CLK_SYS_I);
         if (edg[2] === 1'b1) hits++;
      end
      chk(40'(hits), 40'h1);
      // Two low samples must not reach the filtered level
      board[2] = 1'b0;
      cy(2);
      board[2] = 1'b1;
      board[8] = 1'b1;
      board[38] = 1'b1;
      hits = 0;
      nmi_hits = 0;
      repeat (12) begin
         @(negedge CLK_SYS_I);
         if (edg[2] === 1'b1) hits++;
         if (edg[8] === 1'b1) nmi_hits++;
      end
      chk(40'(hits), 40'h0);
      chk(40'(nmi_hits), 40'h1);
      chk({in0[38], in0[8]}, 2'h3);
      $display("done: filtered edge");
      wr(3, pmx_pkg::REG_DIR, 0, 0, 8'h00);
      wr(1, pmx_pkg::REG_MODE, 0, 0, 8'h00);
      rd(3, pmx_pkg::REG_DIR, 0, 0, 8'h0F);
      rd(1, pmx_pkg::REG_MODE, 0, 0, 8'h01);
      wr(0, pmx_pkg::REG_MEM_MODE, 0, 0, 8'h00);
      cy(3);
      chk(pin_oe[23:16], 40'h0);
      rd(2, pmx_pkg::REG_MEM_MODE, 0, 0, 8'h00);
      wr(0, pmx_pkg::REG_MEM_MODE, 0, 0, 8'h01);
      cy(3);
      chk(pin_oe[23:16], per_oe[23:16]);
      $display("done: fixed bits and memory mode");
      strap = 1'b1;
      RST_I = 1'b1;
      cy(2);
      RST_I = 1'b0;
      cy(6);
      chk({mm[0], pin_oe[23:16]}, 40'h0);
      $display("done: strapped reset");
      cy(2);
      test_done();
   end
endmodule

// ===== tb/pmx_port_mux_sva.sv
// Checker for pmx_port_mux, bound to every instance.
// Assumes peripheral oe is steady while bus pins are judged.
`timescale 1ns/1ns
module pmx_port_mux_sva (
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire logic WR_STB_I,
   input wire logic [2:0] WR_REG_I,
   input wire logic WR_BIT_I,
   input wire logic [7:0] WR_DATA_I,
   input wire logic RD_STB_I,
   input wire logic RD_VALID_O,
   input wire logic [39:0] PIN_I,
   input wire logic [39:0] PIN_O,
   input wire logic [39:0] PIN_OE_O,
   input wire logic [39:0] CTL_OE_I,
   input wire logic [39:0] CTL_IN0_O,
   input wire logic [39:0] CTL_EDGE_O,
   input wire logic [7:0] MEM_MODE_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   sequence s_mm_wr;
      WR_STB_I && WR_REG_I == 3'h4 && !WR_BIT_I;
   endsequence
   sequence s_wait_hi;
      PIN_I[38] [*5];
   endsequence
   AST_RD_ANSWER: assert property (RD_STB_I |=> RD_VALID_O)
      else $error("read not answered");
   AST_RD_NO_EXTRA: assert property (!RD_STB_I |=> !RD_VALID_O)
      else $error("read answer without request");
   AST_ANALOG_NO_OE: assert property (PIN_OE_O[31:24] == 8'h00)
      else $error("analog pin driven");
   AST_NMI_NO_OE: assert property (!PIN_OE_O[8])
      else $error("interrupt pin driven");
   AST_CLK_OUT: assert property (!$past(RST_I) && !$past(RST_I, 2) |->
      PIN_OE_O[39] && PIN_O[39] != $past(PIN_O[39]))
      else $error("clock output not running");
   AST_WAIT_IN: assert property (s_wait_hi |-> CTL_IN0_O[38])
      else $error("wait input not passed on");
   AST_MEM_MODE: assert property (s_mm_wr |=>
      MEM_MODE_O[0] == $past(WR_DATA_I[0]))
      else $error("memory mode not taken");
   AST_BUS_PINS: assert property (MEM_MODE_O[0] && $past(MEM_MODE_O[0])
      && $past(MEM_MODE_O[0], 2) && $stable(CTL_OE_I[23:16])
      |-> PIN_OE_O[23:16] == CTL_OE_I[23:16])
      else $error("bus pins not handed over");
   AST_EDGE_BITS: assert property ((CTL_EDGE_O & ~40'h0000000104) == 40'h0)
      else $error("edge on unfiltered bit");
   AST_EDGE_PULSE: assert property (CTL_EDGE_O[2] |->
      $past(PIN_I[2], 2) ##1 !CTL_EDGE_O[2])
      else $error("edge pulse wrong");
endmodule
bind pmx_port_mux pmx_port_mux_sva u_sva (.CLK_SYS_I, .RST_I, .WR_STB_I,
   .WR_REG_I, .WR_BIT_I, .WR_DATA_I, .RD_STB_I, .RD_VALID_O, .PIN_I, .PIN_O,
   .PIN_OE_O, .CTL_OE_I, .CTL_IN0_O, .CTL_EDGE_O, .MEM_MODE_O);
